/* File: src/ocm_pkg.sv */
/*
  Shared constants and types for the oscillator control and clock fail monitor:
  register offset, field positions, reset values, stall timeouts and state records.
  Assumes a single 200 MHz pclk domain that carries all register and monitor state.
*/
package ocm_pkg;

  // ----------------------------------------------------------------
  // bus and clock
  // ----------------------------------------------------------------
  localparam int          OCM_ADDR_W       = 12;
  localparam int          OCM_PCLK_MHZ     = 200;
  localparam logic [11:0] OCM_OSC_CTL_ADDR = 12'h000;

  // ----------------------------------------------------------------
  // oscillator_control field positions
  // ----------------------------------------------------------------
  localparam int OCM_LF_FAIL_STA_BIT  = 31;
  localparam int OCM_ROOT_FAIL_BIT    = 30;
  localparam int OCM_ROOT_AUTOSW_BIT  = 21;
  localparam int OCM_ROOT_WATCH_BIT   = 20;
  localparam int OCM_RSVD_HI_MSB      = 16;
  localparam int OCM_RSVD_HI_LSB      = 15;
  localparam int OCM_RSVD_14_BIT      = 14;
  localparam int OCM_LF_SWITCHED_BIT  = 13;
  localparam int OCM_LF_AUTOSW_BIT    = 12;
  localparam int OCM_HF_STABLE_BIT    = 11;
  localparam int OCM_LF_MON_EN_BIT    = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  OCM_RSVD_HI_RST  = 2'h3;
  localparam logic        OCM_RSVD_14_RST  = 1'h1;
  localparam logic [31:0] OCM_RDATA_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // stall timeouts, each in its own unit and then in pclk cycles
  // ----------------------------------------------------------------
  localparam int OCM_ROOT_STALL_NS  = 2500;
  localparam int OCM_ROOT_STALL_CYC = (OCM_ROOT_STALL_NS * OCM_PCLK_MHZ + 999) / 1000;
  localparam int OCM_LF_STALL_US    = 2000;
  localparam int OCM_LF_STALL_CYC   = OCM_LF_STALL_US * OCM_PCLK_MHZ;
  localparam int OCM_WATCH_CNT_W    = 20;

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       sync1;
    logic                       sync2;
    logic                       prev;
    logic [OCM_WATCH_CNT_W-1:0] count;
    logic                       tripped;
    logic                       stall;
  } ocm_watch_t;

  typedef struct packed {
    logic        root_watch_en;
    logic        root_autosw_en;
    logic [1:0]  rsvd_hi;
    logic        rsvd_14;
    logic        lf_autosw_en;
    logic        lf_mon_en;
    logic        lf_fail_sta;
    logic        root_fail;
    logic        lf_switched;
    logic        root_on_hf;
    logic        hf_stable;
    logic        hfx_en_s1;
    logic        hfx_en_s2;
    logic        hfx_rdy_s1;
    logic        hfx_rdy_s2;
    logic        act_s1;
    logic        act_s2;
    logic [31:0] prdata;
    logic        pslverr;
  } ocm_state_t;

endpackage : ocm_pkg

/* File: src/ocm_clk_watch.sv */
/*
  Clock activity watchdog: synchronises a foreign clock into pclk, looks for
  transitions and gives one stall pulse when none is seen for LIMIT cycles.
  Assumes the watched clock is well below half the pclk rate.
*/
`timescale 1ns/10ps
module ocm_clk_watch
  import ocm_pkg::*;
#(
  parameter int LIMIT = OCM_ROOT_STALL_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // watched clock and control
  input  wire logic watched_clk,
  input  wire logic enable,
  // result
  output logic      stall_pulse
);

  localparam logic [OCM_WATCH_CNT_W-1:0] LIMIT_C = OCM_WATCH_CNT_W'(LIMIT);

  ocm_watch_t q;
  ocm_watch_t d;
  logic       toggled;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.sync1 = watched_clk;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    toggled = q.sync2 != q.prev;
    if (!enable) begin
      // disabled watchdog is held cleared so no stall can be reported
      d.count   = '0;
      d.tripped = 1'b0;
    end else if (toggled) begin
      d.count   = '0;
      d.tripped = 1'b0;
    end else if (q.count != LIMIT_C) begin
      d.count = q.count + OCM_WATCH_CNT_W'(1);
    end
    if (enable && !toggled && q.count == LIMIT_C) begin
      d.tripped = 1'b1;
    end
    // one pulse per stall, re-armed by the next transition
    d.stall = d.tripped & ~q.tripped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign stall_pulse = q.stall;

endmodule : ocm_clk_watch

/* File: src/ocm_top.sv */
/*
  Oscillator control register with root clock and low-frequency crystal
  failure monitors, low-frequency mux auto-switch and crystal stable status.
  Assumes an APB master on pclk; clocks and oscillator status arrive as pins.
*/
// Local design decisions: the APB register port and the placing of the registers.
// Behaviour
// R1 - with the root watch enable set and the part active, the root clock is watched against the fast reference.
// R2 - a root clock without transitions for 2.5 us sets the root fail flag and raises the root fail interrupt.
// R3 - with the root watch enable clear the root watchdog is held in reset and no root interrupt is given.
// R4 - software keeps the reserved field at bits 16:15 at 3 on every write.
// R5 - software keeps reserved bit 14 at 1 on every write.
// R6 - with the autoswitch enable set a crystal failure moves the low-frequency mux to the rc oscillator.
// R7 - the switched flag at bit 13 is set by that move and cleared by writing 1.
// R8 - the crystal stable bit reads 1 once the crystal is enabled and stable, 0 while disabled or not yet stable.
// R9 - the crystal stable bit does not drop on a later loss of stability.
// R10 - with its monitor enabled a low-frequency crystal stalled for 2 ms is flagged in any power mode.
// R11 - the crystal fail status is sticky, drives the rtc interrupt and is cleared by writing 1.
// R12 - the root clock moves to the fast rc oscillator only while root watching is enabled.
// R13 - writing 0 leaves the switched flag alone and a hardware set beats a simultaneous clear.
`timescale 1ns/10ps
module ocm_top
  import ocm_pkg::*;
#(
  parameter int ROOT_STALL_CYC = OCM_ROOT_STALL_CYC,
  parameter int LF_STALL_CYC   = OCM_LF_STALL_CYC
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [OCM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // monitored clocks and oscillator status pins
  input  wire logic                  root_clk_in,
  input  wire logic                  lf_crystal_clk_in,
  input  wire logic                  hf_crystal_enable,
  input  wire logic                  hf_crystal_ready,
  input  wire logic                  active_mode,
  // interrupts and mux controls
  output logic                       root_fail_irq,
  output logic                       rtc_irq,
  output logic                       lf_mux_select_rc,
  output logic                       root_mux_select_hf
);

  ocm_state_t  q;
  ocm_state_t  d;
  logic        root_stall;
  logic        lf_stall;
  logic        root_watch_run;
  logic        wr_hit;
  logic        setup_rd;
  logic        addr_ok;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // clock watchdogs
  // ----------------------------------------------------------------
  // R1 active-mode watching
  assign root_watch_run = q.root_watch_en & q.act_s2;

  // R3 held in reset
  ocm_clk_watch #(
    .LIMIT (ROOT_STALL_CYC)
  ) u_root_watch (
    .pclk        (pclk),
    .presetn     (presetn),
    .watched_clk (root_clk_in),
    .enable      (root_watch_run),
    .stall_pulse (root_stall)
  );

  // R10 any power mode
  ocm_clk_watch #(
    .LIMIT (LF_STALL_CYC)
  ) u_lf_watch (
    .pclk        (pclk),
    .presetn     (presetn),
    .watched_clk (lf_crystal_clk_in),
    .enable      (q.lf_mon_en),
    .stall_pulse (lf_stall)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // unmapped addresses answer with pslverr; reads of them return zero
  assign addr_ok  = paddr == OCM_OSC_CTL_ADDR;
  assign setup_rd = psel & ~penable;
  assign wr_hit   = psel & penable & pwrite & addr_ok;
  assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wbits    = pwdata & wmask;

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  always_comb begin
    rd_word                                   = '0;
    rd_word[OCM_LF_FAIL_STA_BIT]              = q.lf_fail_sta;
    rd_word[OCM_ROOT_FAIL_BIT]                = q.root_fail;
    rd_word[OCM_ROOT_AUTOSW_BIT]              = q.root_autosw_en;
    rd_word[OCM_ROOT_WATCH_BIT]               = q.root_watch_en;
    rd_word[OCM_RSVD_HI_MSB:OCM_RSVD_HI_LSB]  = q.rsvd_hi;
    rd_word[OCM_RSVD_14_BIT]                  = q.rsvd_14;
    rd_word[OCM_LF_SWITCHED_BIT]              = q.lf_switched;
    rd_word[OCM_LF_AUTOSW_BIT]                = q.lf_autosw_en;
    // R8 stable status
    rd_word[OCM_HF_STABLE_BIT]                = q.hf_stable;
    rd_word[OCM_LF_MON_EN_BIT]                = q.lf_mon_en;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // pin synchronisers; first stages feed only the second
    d.hfx_en_s1  = hf_crystal_enable;
    d.hfx_en_s2  = q.hfx_en_s1;
    d.hfx_rdy_s1 = hf_crystal_ready;
    d.hfx_rdy_s2 = q.hfx_rdy_s1;
    d.act_s1     = active_mode;
    d.act_s2     = q.act_s1;

    // control fields; the reserved ones store whatever software writes,
    // keeping them at their reset value is left to software
    if (wr_hit) begin
      if (pstrb[2]) begin
        d.root_autosw_en = pwdata[OCM_ROOT_AUTOSW_BIT];
        d.root_watch_en  = pwdata[OCM_ROOT_WATCH_BIT];
        d.rsvd_hi[1]     = pwdata[OCM_RSVD_HI_MSB];
      end
      if (pstrb[1]) begin
        // R4 low bit 15 of reserved pair stored
        d.rsvd_hi[0]     = pwdata[OCM_RSVD_HI_LSB];
        // R5 reserved bit stored
        d.rsvd_14        = pwdata[OCM_RSVD_14_BIT];
        // R6 autoswitch control
        d.lf_autosw_en   = pwdata[OCM_LF_AUTOSW_BIT];
      end
      if (pstrb[0]) begin
        d.lf_mon_en      = pwdata[OCM_LF_MON_EN_BIT];
      end
    end

    // write-1-to-clear of the sticky flags
    if (wr_hit && wbits[OCM_ROOT_FAIL_BIT]) begin
      d.root_fail  = 1'b0;
      d.root_on_hf = 1'b0;
    end
    if (wr_hit && wbits[OCM_LF_FAIL_STA_BIT]) begin
      d.lf_fail_sta = 1'b0;
    end
    // R7 write one clears
    if (wr_hit && wbits[OCM_LF_SWITCHED_BIT]) begin
      d.lf_switched = 1'b0;
    end

    // hardware sets come last so that they win over a clear in the same cycle
    // R2 root stall sets flag
    if (root_stall && q.root_watch_en) begin
      d.root_fail = 1'b1;
      // R12 root switch gated
      if (q.root_autosw_en) begin
        d.root_on_hf = 1'b1;
      end
    end
    // R11 sticky crystal fail
    if (lf_stall && q.lf_mon_en) begin
      d.lf_fail_sta = 1'b1;
      // R13 set beats clear
      if (q.lf_autosw_en) begin
        d.lf_switched = 1'b1;
      end
    end

    // R9 latch, no monitoring
    if (!q.hfx_en_s2) begin
      d.hf_stable = 1'b0;
    end else if (q.hfx_rdy_s2) begin
      d.hf_stable = 1'b1;
    end

    // read data and error are prepared in the setup cycle, so the access
    // phase completes with zero wait states from flip-flop outputs
    if (setup_rd) begin
      d.prdata  = (addr_ok && !pwrite) ? rd_word : OCM_RDATA_RST;
      d.pslverr = ~addr_ok;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.rsvd_hi <= OCM_RSVD_HI_RST;
      q.rsvd_14 <= OCM_RSVD_14_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata  = q.prdata;
  assign pready  = 1'b1;
  assign pslverr = q.pslverr & psel & penable;

  // R3 interrupt gated
  assign root_fail_irq      = q.root_fail & q.root_watch_en;
  // R11 rtc line
  assign rtc_irq            = q.lf_fail_sta;
  // R6 mux to rc
  assign lf_mux_select_rc   = q.lf_switched;
  assign root_mux_select_hf = q.root_on_hf;

endmodule : ocm_top

/* File: tb/ocm_props.sv */
/*
  port checker for ocm_top.
  assumes a bind from the bench top file.
*/
`timescale 1ns/10ps
module ocm_props
  import ocm_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        root_fail_irq,
  input wire logic        rtc_irq,
  input wire logic        lf_mux_select_rc,
  input wire logic        root_mux_select_hf
);
  logic wr0;
  assign wr0 = psel && penable && pwrite && paddr == OCM_OSC_CTL_ADDR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bad_acc;
    psel && penable && paddr != OCM_OSC_CTL_ADDR;
  endsequence
  sequence s_clr_switch;
    wr0 && pstrb[1] && pwdata[13];
  endsequence
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (s_bad_acc |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr == OCM_OSC_CTL_ADDR |-> !pslverr) else $error("mapped error");
  a_reset_quiet: assert property ($rose(presetn) |-> !(root_fail_irq || rtc_irq || lf_mux_select_rc))
    else $error("outputs busy after reset");
  a_rtc_sticky: assert property (rtc_irq && !(wr0 && pstrb[3] && pwdata[31]) |=> rtc_irq)
    else $error("rtc irq dropped");
  a_rtc_clear: assert property (wr0 && pstrb[3] && pwdata[31] |=> !rtc_irq) else $error("rtc not cleared");
  a_switch_sticky: assert property (lf_mux_select_rc && !(wr0 && pstrb[1] && pwdata[13]) |=> lf_mux_select_rc)
    else $error("switch dropped");
  a_switch_clear: assert property (s_clr_switch |=> !lf_mux_select_rc) else $error("switch not cleared");
  a_root_clear: assert property (wr0 && pstrb[3] && pwdata[30] |=> !root_fail_irq) else $error("root kept");
  a_root_mask: assert property (wr0 && pstrb[2] && !pwdata[20] |=> !root_fail_irq) else $error("root unmasked");
endmodule : ocm_props

/* File: tb/ocm_top_test.sv */
/*
  bench for ocm_top: apb tasks and one task a scenario.
  assumes shortened stall counts and the checker ocm_props.
*/
`timescale 1ns/10ps
module ocm_top_test import ocm_pkg::*;;
  // reserved pair 16:15 at 3 and reserved bit 14 at 1, kept on every write
  localparam logic [31:0] RSV = 32'h0001_C000;
  localparam logic [11:0] A = OCM_OSC_CTL_ADDR;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, root_fail_irq, rtc_irq, lf_mux_select_rc, root_mux_select_hf, err;
  logic root_clk_in = 1'b0, lf_crystal_clk_in = 1'b0, hf_crystal_enable = 1'b0, hf_crystal_ready = 1'b0;
  logic active_mode = 1'b0, root_run = 1'b1, lf_run = 1'b1;
  logic [2:0] div = 3'h0;
  int num_errors = 0, tests_run = 0;
  always #2.5 pclk = ~pclk;
  // watched clocks at 25 MHz, frozen when stopped
  always @(posedge pclk) begin
    div <= div + 3'h1;
    if (root_run) root_clk_in <= div[2];
    if (lf_run) lf_crystal_clk_in <= div[2];
  end
  ocm_top #(.ROOT_STALL_CYC(50), .LF_STALL_CYC(200)) i_ocm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .root_clk_in(root_clk_in), .lf_crystal_clk_in(lf_crystal_clk_in),
    .hf_crystal_enable(hf_crystal_enable), .hf_crystal_ready(hf_crystal_ready), .active_mode(active_mode),
    .root_fail_irq(root_fail_irq), .rtc_irq(rtc_irq), .lf_mux_select_rc(lf_mux_select_rc),
    .root_mux_select_hf(root_mux_select_hf));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [31:0] m, exp, input string msg);
    apb(1'b0, A, 32'h0);
    check(rd & m, exp, msg);
  endtask : rchk
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(32'hFFFF_FFFF, RSV, "reset value");
    apb(1'b0, 12'h004, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    rchk(32'hFFFF_FFFF, RSV, "unmapped write");
  endtask : t_reset
  task automatic t_root;
    active_mode <= 1'b1;
    root_run <= 1'b0;
    repeat (150) @(posedge pclk);
    rchk(32'h4000_0000, 32'h0, "watch off");
    active_mode <= 1'b0;
    apb(1'b1, A, RSV | 32'h0010_0000);
    repeat (150) @(posedge pclk);
    rchk(32'h4000_0000, 32'h0, "not active");
    active_mode <= 1'b1;
    for (int i = 0; i < 200 && root_fail_irq !== 1'b1; i++) @(posedge pclk);
    check(root_fail_irq, 32'h1, "root irq");
    rchk(32'h4000_0000, 32'h4000_0000, "root flag");
    check(root_mux_select_hf, 32'h0, "root mux");
    apb(1'b1, A, RSV | 32'h4010_0000);
    rchk(32'h4000_0000, 32'h0, "root w1c");
    root_run <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, A, RSV | 32'h0030_0000);
    root_run <= 1'b0;
    for (int i = 0; i < 200 && root_fail_irq !== 1'b1; i++) @(posedge pclk);
    check(root_fail_irq, 32'h1, "root irq again");
    check(root_mux_select_hf, 32'h1, "root mux switched");
    apb(1'b1, A, RSV | 32'h4000_0000);
    check(root_mux_select_hf, 32'h0, "root mux released");
    root_run <= 1'b1;
  endtask : t_root
  task automatic t_lf;
    active_mode <= 1'b0;
    lf_run <= 1'b0;
    apb(1'b1, A, RSV | 32'h20);
    for (int i = 0; i < 400 && rtc_irq !== 1'b1; i++) @(posedge pclk);
    check(rtc_irq, 32'h1, "lf irq");
    check(lf_mux_select_rc, 32'h0, "no switch");
    rchk(32'h8000_2000, 32'h8000_0000, "lf status");
    apb(1'b1, A, RSV | 32'h8000_0020);
    check(rtc_irq, 32'h0, "lf w1c");
    lf_run <= 1'b1;
    repeat (20) @(posedge pclk);
    lf_run <= 1'b0;
    apb(1'b1, A, RSV | 32'h1020);
    for (int i = 0; i < 400 && lf_mux_select_rc !== 1'b1; i++) @(posedge pclk);
    check(lf_mux_select_rc, 32'h1, "switch");
    rchk(32'h2000, 32'h2000, "switched flag");
    apb(1'b1, A, RSV | 32'h1020);
    rchk(32'h2000, 32'h2000, "write 0 kept");
    apb(1'b1, A, RSV | 32'h3020);
    check(lf_mux_select_rc, 32'h0, "switch w1c");
    rchk(32'h2000, 32'h0, "flag w1c");
    lf_run <= 1'b1;
    apb(1'b1, A, RSV | 32'h8000_0000);
  endtask : t_lf
  task automatic t_hf;
    hf_crystal_enable <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(32'h800, 32'h0, "hf not ready");
    hf_crystal_ready <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(32'h800, 32'h800, "hf stable");
    hf_crystal_ready <= 1'b0;
    repeat (6) @(posedge pclk);
    rchk(32'h800, 32'h800, "hf kept");
    hf_crystal_enable <= 1'b0;
    repeat (6) @(posedge pclk);
    rchk(32'h800, 32'h0, "hf off");
  endtask : t_hf
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_root();
    t_lf();
    t_hf();
    close_out();
  end
  // watchdog: whole run needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge pclk);
    num_errors++;
    close_out();
  end
endmodule : ocm_top_test
bind ocm_top ocm_props i_ocm_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .root_fail_irq(root_fail_irq), .rtc_irq(rtc_irq), .lf_mux_select_rc(lf_mux_select_rc),
  .root_mux_select_hf(root_mux_select_hf));
